// ===== sbm_pkg.sv
// Purpose: Shared constants for the reference monitor and comparator self-test block
// Assumes: 100 MHz core clock; register access via a simple documented-style register port
// Notes:   Register indices are local choices; field widths follow regulator counts

package sbm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SBM_ADDR_OV_SW    = 8'h00;
  localparam logic [7:0] SBM_ADDR_OV_LDO   = 8'h01;
  localparam logic [7:0] SBM_ADDR_UV_SW    = 8'h02;
  localparam logic [7:0] SBM_ADDR_UV_LDO   = 8'h03;
  localparam logic [7:0] SBM_ADDR_CTRL     = 8'h04;
  localparam logic [7:0] SBM_ADDR_STATUS   = 8'h05;

  // Control register fields
  localparam int SBM_CTRL_GO_BIT       = 0;
  localparam int SBM_CTRL_BYPASS_BIT   = 1;
  localparam int SBM_CTRL_IRQ_MASK_BIT = 2;
  // Status register fields
  localparam int SBM_STAT_STATE_BIT    = 0;
  localparam int SBM_STAT_IRQ_BIT      = 1;
  localparam int SBM_STAT_BUSY_BIT     = 2;

  localparam logic [7:0] SBM_RESULT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SBM_CLK_MHZ          = 100;
  localparam int SBM_BLANK_MAX_US     = 200;
  // Longest blanking time as an exact count of core clock cycles
  localparam int SBM_BLANK_MAX_CYC    = SBM_BLANK_MAX_US * SBM_CLK_MHZ;
  localparam int SBM_SETTLE_CYC_DFLT  = 16;

  typedef enum logic [2:0] {
    SBM_IDLE,
    SBM_FORCE_HI,
    SBM_SAMPLE_HI,
    SBM_FORCE_LO,
    SBM_SAMPLE_LO,
    SBM_DONE
  } sbm_state_t;

endpackage : sbm_pkg

// ===== sbm_selftest.sv
// Purpose: Reference-mismatch monitor and over/under-voltage comparator self-test control
// Assumes: All inputs synchronous to core_clk_i; analog flags are already debounced
// Notes:   Comparator forcing is done by test-drive outputs; results captured per regulator

`timescale 1ns/10ps

// Functional notes
// RULE1 - Reference mismatch of 4-12 percent is critical; block switcher power-up.
// RULE2 - Mismatch at power-up fails self-test and blocks power-up, ignoring bypass.
// RULE3 - In system-on with bypass 0, mismatch shuts regulator power stages down.
// RULE4 - In system-on with bypass 1, mismatch only raises interrupt; regulators run.
// RULE5 - Reference-fault interrupt flag asserts on failure unless masked.
// RULE6 - Reference-fault state bit tracks live mismatch: 0 in range, 1 out.
// RULE7 - Self-test exercises OV and UV comparators of every switcher and linear.
// RULE8 - Each comparator must toggle; a non-toggling one sets its own warning bit.
// RULE9 - Results sit in four registers: OV/UV for switchers and linears.
// RULE10 - Every self-test run overwrites all four result registers.
// RULE11 - With secure writes on, only secure writes may clear result registers.
// RULE12 - After power-up self-test, sequencing continues regardless of comparator results.
// RULE13 - Writing 1 to the go bit tests all OV and UV comparators.
// RULE14 - Go bit self-clears when the on-demand test finishes; rerun is allowed.
// RULE15 - With secure writes on, host must set go bit by secure write.
// RULE16 - On-demand test blanks OV/UV fault reporting at most 200 microseconds.
// RULE17 - Host requests on-demand test only in a safe system state.
// RULE18 - On-demand comparator failures set the matching per-regulator flags.
// RULE19 - Host reads and checks flags after each run and reacts to failures.
// RULE20 - Writes of 1 to the go bit are ignored while a test runs.
module sbm_selftest #(
  parameter int NUM_SW     = 7,
  parameter int NUM_LDO    = 4,
  parameter int SETTLE_CYC = sbm_pkg::SBM_SETTLE_CYC_DFLT
) (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       srst_i,
  // Register port
  input  wire logic       reg_wr_i,
  input  wire logic       reg_secure_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Configuration and system state
  input  wire logic       secure_en_i,
  input  wire logic       powerup_test_i,
  input  wire logic       system_on_i,
  // Reference comparison
  input  wire logic       ref_mismatch_i,
  // Comparator outputs and forcing
  input  wire logic [NUM_SW-1:0]  sw_ov_cmp_i,
  input  wire logic [NUM_SW-1:0]  sw_uv_cmp_i,
  input  wire logic [NUM_LDO-1:0] ldo_ov_cmp_i,
  input  wire logic [NUM_LDO-1:0] ldo_uv_cmp_i,
  output logic                    cmp_force_hi_o,
  output logic                    cmp_force_lo_o,
  // Safety outputs
  output logic       fault_blank_o,
  output logic       switcher_powerup_block_o,
  output logic       power_stage_shutdown_o,
  output logic       reference_fault_irq_o,
  output logic       selftest_done_o
);
  import sbm_pkg::*;

  initial begin
    if (NUM_SW < 1 || NUM_SW > 8 || NUM_LDO < 1 || NUM_LDO > 8)
      $error("sbm_selftest: regulator counts must be 1..8");
    if (SETTLE_CYC < 1 || 4 * SETTLE_CYC + 4 > SBM_BLANK_MAX_CYC)
      $error("sbm_selftest: settle time breaks blanking limit");
    if (SBM_BLANK_MAX_CYC < 2)
      $error("sbm_selftest: blanking limit too short to count");
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  logic wr_ctrl;
  logic go_req;
  // Result registers need a secure write when the feature is on
  logic res_wr_ok;
  assign wr_ctrl   = reg_wr_i && hit(reg_addr_i, SBM_ADDR_CTRL);
  assign res_wr_ok = reg_wr_i && (reg_secure_i || !secure_en_i);  // [RULE11]
  assign go_req    = wr_ctrl && reg_wdata_i[SBM_CTRL_GO_BIT]
                     && (reg_secure_i || !secure_en_i);  // [RULE15]

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic go_reg;
  logic bypass_reg;
  logic irq_mask_reg;
  sbm_state_t state_reg;
  sbm_state_t state_next;
  logic ondemand_reg;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bypass_reg   <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else if (wr_ctrl) begin
      bypass_reg   <= reg_wdata_i[SBM_CTRL_BYPASS_BIT];
      irq_mask_reg <= reg_wdata_i[SBM_CTRL_IRQ_MASK_BIT];
    end
  end

  // Go bit: set by host, cleared by hardware on completion
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      go_reg <= 1'b0;
    end else if (state_reg == SBM_DONE) begin
      go_reg <= 1'b0;  // [RULE14]
    end else if (go_req && state_reg == SBM_IDLE) begin
      go_reg <= 1'b1;  // [RULE13] [RULE20]
    end
  end

  // ----------------------------------------------------------------
  // Self-test sequencer
  // ----------------------------------------------------------------
  localparam int CW = $clog2(SETTLE_CYC + 1);
  logic [CW-1:0] settle_reg;
  logic          settle_done;
  logic          start;
  assign settle_done = (settle_reg == CW'(SETTLE_CYC - 1));
  assign start       = (go_req && state_reg == SBM_IDLE) || powerup_test_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SBM_IDLE:      if (start) state_next = SBM_FORCE_HI;
      SBM_FORCE_HI:  if (settle_done) state_next = SBM_SAMPLE_HI;
      SBM_SAMPLE_HI: state_next = SBM_FORCE_LO;
      SBM_FORCE_LO:  if (settle_done) state_next = SBM_SAMPLE_LO;
      SBM_SAMPLE_LO: state_next = SBM_DONE;
      SBM_DONE:      state_next = SBM_IDLE;
      default:       state_next = SBM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= SBM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || state_next != state_reg) begin
      settle_reg <= '0;
    end else if (!settle_done) begin
      settle_reg <= settle_reg + CW'(1);
    end
  end

  // Power-up runs are distinguished so blanking only applies on demand
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ondemand_reg <= 1'b0;
    end else if (state_reg == SBM_IDLE && start) begin
      ondemand_reg <= !powerup_test_i;
    end
  end

  // Drive all comparators high then low; both phases must be seen
  assign cmp_force_hi_o = (state_reg == SBM_FORCE_HI) || (state_reg == SBM_SAMPLE_HI);  // [RULE7]
  assign cmp_force_lo_o = (state_reg == SBM_FORCE_LO) || (state_reg == SBM_SAMPLE_LO);  // [RULE7]

  // Whole sequence is bounded to about half of 200 us by the elaboration check
  logic blank_raw;
  assign blank_raw       = ondemand_reg && (state_reg != SBM_IDLE);
  assign selftest_done_o = (state_reg == SBM_DONE);

  // ----------------------------------------------------------------
  // Blanking guard
  // ----------------------------------------------------------------
  // Independent of the sequencer: even a stuck state machine cannot
  // keep fault reporting off past the limit
  localparam int BW = $clog2(SBM_BLANK_MAX_CYC + 1);
  logic [BW-1:0] blank_cnt_reg;
  logic          blank_expired;
  assign blank_expired = (blank_cnt_reg == BW'(SBM_BLANK_MAX_CYC - 1));

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !blank_raw) begin
      blank_cnt_reg <= '0;
    end else if (!blank_expired) begin
      blank_cnt_reg <= blank_cnt_reg + BW'(1);
    end
  end

  assign fault_blank_o = blank_raw && !blank_expired;  // [RULE16]

  // ----------------------------------------------------------------
  // Toggle capture and result registers
  // ----------------------------------------------------------------
  logic [NUM_SW-1:0]  sw_ov_hi_reg;
  logic [NUM_SW-1:0]  sw_uv_hi_reg;
  logic [NUM_LDO-1:0] ldo_ov_hi_reg;
  logic [NUM_LDO-1:0] ldo_uv_hi_reg;
  logic [7:0] ov_sw_reg;
  logic [7:0] ov_ldo_reg;
  logic [7:0] uv_sw_reg;
  logic [7:0] uv_ldo_reg;

  // One capture cell per switcher, holding what it read while forced high
  for (genvar i = 0; i < NUM_SW; i++) begin : g_sw_cap
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        sw_ov_hi_reg[i] <= 1'b0;
        sw_uv_hi_reg[i] <= 1'b0;
      end else if (state_reg == SBM_SAMPLE_HI) begin
        sw_ov_hi_reg[i] <= sw_ov_cmp_i[i];  // [RULE7]
        sw_uv_hi_reg[i] <= sw_uv_cmp_i[i];  // [RULE7]
      end
    end
  end

  // One capture cell per linear regulator
  for (genvar j = 0; j < NUM_LDO; j++) begin : g_ldo_cap
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        ldo_ov_hi_reg[j] <= 1'b0;
        ldo_uv_hi_reg[j] <= 1'b0;
      end else if (state_reg == SBM_SAMPLE_HI) begin
        ldo_ov_hi_reg[j] <= ldo_ov_cmp_i[j];  // [RULE7]
        ldo_uv_hi_reg[j] <= ldo_uv_cmp_i[j];  // [RULE7]
      end
    end
  end

  // A comparator passes only if it read 1 when forced high and 0 when forced low
  function automatic logic [7:0] fails(input logic [7:0] hi, input logic [7:0] lo, input int n);
    logic [7:0] m;
    m = 8'hFF >> (8 - n);
    fails = ~(hi & ~lo) & m;
  endfunction : fails

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ov_sw_reg  <= SBM_RESULT_RESET;
      ov_ldo_reg <= SBM_RESULT_RESET;
      uv_sw_reg  <= SBM_RESULT_RESET;
      uv_ldo_reg <= SBM_RESULT_RESET;
    end else if (state_reg == SBM_SAMPLE_LO) begin
      // Fresh outcome replaces old one; a pending clear loses to it
      ov_sw_reg  <= fails(8'(sw_ov_hi_reg),  8'(sw_ov_cmp_i),  NUM_SW);   // [RULE8] [RULE9] [RULE10] [RULE18]
      ov_ldo_reg <= fails(8'(ldo_ov_hi_reg), 8'(ldo_ov_cmp_i), NUM_LDO);  // [RULE8] [RULE9] [RULE10] [RULE18]
      uv_sw_reg  <= fails(8'(sw_uv_hi_reg),  8'(sw_uv_cmp_i),  NUM_SW);   // [RULE8] [RULE9] [RULE10] [RULE18]
      uv_ldo_reg <= fails(8'(ldo_uv_hi_reg), 8'(ldo_uv_cmp_i), NUM_LDO);  // [RULE8] [RULE9] [RULE10] [RULE18]
    end else if (res_wr_ok) begin
      // Write-1-to-clear
      if (hit(reg_addr_i, SBM_ADDR_OV_SW))  ov_sw_reg  <= ov_sw_reg  & ~reg_wdata_i;  // [RULE11]
      if (hit(reg_addr_i, SBM_ADDR_OV_LDO)) ov_ldo_reg <= ov_ldo_reg & ~reg_wdata_i;  // [RULE11]
      if (hit(reg_addr_i, SBM_ADDR_UV_SW))  uv_sw_reg  <= uv_sw_reg  & ~reg_wdata_i;  // [RULE11]
      if (hit(reg_addr_i, SBM_ADDR_UV_LDO)) uv_ldo_reg <= uv_ldo_reg & ~reg_wdata_i;  // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // Reference monitor
  // ----------------------------------------------------------------
  logic irq_flag_reg;
  logic pu_block_reg;
  logic shutdown_reg;
  logic clr_irq;
  assign clr_irq = reg_wr_i && hit(reg_addr_i, SBM_ADDR_STATUS)
                   && reg_wdata_i[SBM_STAT_IRQ_BIT];

  // Set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_flag_reg <= 1'b0;
    end else if (ref_mismatch_i) begin
      irq_flag_reg <= 1'b1;  // [RULE5] [RULE4]
    end else if (clr_irq) begin
      irq_flag_reg <= 1'b0;
    end
  end
  assign reference_fault_irq_o = irq_flag_reg && !irq_mask_reg;  // [RULE5]

  // Power-up blocking is latched until reset, bypass has no say here
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pu_block_reg <= 1'b0;
    end else if (ref_mismatch_i && !system_on_i) begin
      pu_block_reg <= 1'b1;  // [RULE1] [RULE2]
    end
  end

  // Power-up self-test verdict on the reference: failed for good once a
  // mismatch is seen before system-on, whatever the bypass bit says
  logic ref_st_fail_reg;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ref_st_fail_reg <= 1'b0;
    end else if (ref_mismatch_i && !system_on_i) begin
      ref_st_fail_reg <= 1'b1;  // [RULE2]
    end
  end

  // Comparator results never hold off power-up; only the reference check does
  assign switcher_powerup_block_o = pu_block_reg;  // [RULE12]

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      shutdown_reg <= 1'b0;
    end else if (ref_mismatch_i && system_on_i && !bypass_reg) begin
      shutdown_reg <= 1'b1;  // [RULE3]
    end
  end
  assign power_stage_shutdown_o = shutdown_reg;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Status: live reference state, irq flag, busy, power-up reference verdict
  logic [7:0] status_word;
  assign status_word = {4'h0, ref_st_fail_reg, (state_reg != SBM_IDLE),
                        irq_flag_reg, ref_mismatch_i};  // [RULE6]

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        SBM_ADDR_OV_SW:  reg_rdata_o <= ov_sw_reg;
        SBM_ADDR_OV_LDO: reg_rdata_o <= ov_ldo_reg;
        SBM_ADDR_UV_SW:  reg_rdata_o <= uv_sw_reg;
        SBM_ADDR_UV_LDO: reg_rdata_o <= uv_ldo_reg;
        SBM_ADDR_CTRL:   reg_rdata_o <= {5'b0_0000, irq_mask_reg, bypass_reg, go_reg};
        SBM_ADDR_STATUS: reg_rdata_o <= status_word;  // [RULE6]
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule : sbm_selftest

// ===== sbm_cmp_model.sv
// Purpose: Comparator front end answering the block's forcing outputs
// Assumes: Forcing high trips every healthy comparator, release drops it
// Notes:   Faulty comparators stick at stuck_val_i and so never toggle

`timescale 1ns/10ps

module sbm_cmp_model (
  // Forcing from the block
  input  wire logic        force_hi_i,
  input  wire logic        force_lo_i,
  // Faults, packed {sw_ov, sw_uv, ldo_ov, ldo_uv}
  input  wire logic [21:0] bad_i,
  input  wire logic        stuck_val_i,
  // Comparator outputs
  output logic      [21:0] cmp_o
);
  logic [21:0] healthy;
  // Unforced comparators sit low, as a regulator in range would
  assign healthy = {22{force_hi_i & ~force_lo_i}};
  assign cmp_o   = (healthy & ~bad_i) | ({22{stuck_val_i}} & bad_i);
endmodule : sbm_cmp_model

// ===== sbm_selftest_assertions.sv
// Purpose: Timing and cause checks on the self-test and reference ports
// Assumes: Bound onto sbm_selftest with the same SETTLE_CYC
// Notes:   Blank length is counted in helper logic, too long to unroll

`timescale 1ns/10ps

module sbm_selftest_assertions #(
  parameter int SETTLE_CYC = 2
) (
  // Clock, reset and inputs
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic system_on_i,
  input  wire logic ref_mismatch_i,
  // Watched outputs
  input  wire logic cmp_force_hi_o,
  input  wire logic cmp_force_lo_o,
  input  wire logic fault_blank_o,
  input  wire logic switcher_powerup_block_o,
  input  wire logic power_stage_shutdown_o,
  input  wire logic selftest_done_o
);
  import sbm_pkg::*;
  localparam int HI_LEN  = SETTLE_CYC + 1;
  localparam int RUN_LEN = 2 * SETTLE_CYC + 2;
  int unsigned blank_cnt;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !fault_blank_o) blank_cnt <= 0;
    else blank_cnt <= blank_cnt + 1;
  end
  chk_blank_bound: assert property (fault_blank_o |-> blank_cnt < SBM_BLANK_MAX_CYC)
    else $error("blanking too long");
  chk_force_excl: assert property (!(cmp_force_hi_o && cmp_force_lo_o))
    else $error("both forcing outputs high");
  chk_hi_length: assert property ($rose(cmp_force_hi_o) |-> ##HI_LEN (!cmp_force_hi_o && cmp_force_lo_o))
    else $error("high phase length wrong");
  chk_run_length: assert property ($rose(cmp_force_hi_o) |-> ##RUN_LEN selftest_done_o)
    else $error("done not on time");
  chk_lo_then_done: assert property ($fell(cmp_force_lo_o) |-> selftest_done_o)
    else $error("low phase not ended by done");
  chk_done_pulse: assert property (selftest_done_o |=> !selftest_done_o)
    else $error("done longer than one cycle");
  chk_block_sets: assert property (ref_mismatch_i && !system_on_i |=> switcher_powerup_block_o)
    else $error("power-up not blocked");
  chk_block_cause: assert property ($rose(switcher_powerup_block_o)
    |-> $past(ref_mismatch_i && !system_on_i))
    else $error("block without mismatch");
  chk_shut_cause: assert property ($rose(power_stage_shutdown_o) |-> $past(ref_mismatch_i && system_on_i))
    else $error("shutdown without cause");
endmodule : sbm_selftest_assertions

// ===== tb.sv
// Purpose: Register-level tests of the self-test and reference monitor
// Assumes: SETTLE_CYC of 2 shortens each run to 7 cycles
// Notes:   Stuck comparator faults come from sbm_cmp_model

`timescale 1ns/10ps

module tb;
  import sbm_pkg::*;
  localparam int SC = 2;
  logic        core_clk_i, srst_i = 1'h1, reg_wr_i = 1'h0, reg_secure_i = 1'h0;
  logic        secure_en_i = 1'h0, powerup_test_i = 1'h0, system_on_i = 1'h0;
  logic        ref_mismatch_i = 1'h0, stuck = 1'h0;
  logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, done_cnt;
  logic [21:0] bad = 22'h0, cmp;
  logic        f_hi, f_lo, blank, blk, shut, irq, done;
  int          error_cnt = 0, tests_run = 0;

  sbm_selftest #(.SETTLE_CYC(SC)) dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_secure_i(reg_secure_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .secure_en_i(secure_en_i), .powerup_test_i(powerup_test_i), .system_on_i(system_on_i),
    .ref_mismatch_i(ref_mismatch_i), .sw_ov_cmp_i(cmp[21:15]), .sw_uv_cmp_i(cmp[14:8]),
    .ldo_ov_cmp_i(cmp[7:4]), .ldo_uv_cmp_i(cmp[3:0]), .cmp_force_hi_o(f_hi),
    .cmp_force_lo_o(f_lo), .fault_blank_o(blank), .switcher_powerup_block_o(blk),
    .power_stage_shutdown_o(shut), .reference_fault_irq_o(irq), .selftest_done_o(done));
  sbm_cmp_model u_cmp (.force_hi_i(f_hi), .force_lo_i(f_lo), .bad_i(bad), .stuck_val_i(stuck), .cmp_o(cmp));

  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    if (srst_i) done_cnt <= 8'h00;
    else if (done === 1'h1) done_cnt <= done_cnt + 8'h01;
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge core_clk_i);
    reg_wr_i     <= 1'h1;
    reg_addr_i   <= a;
    reg_wdata_i  <= d;
    reg_secure_i <= s;
    @(posedge core_clk_i);
    reg_wr_i     <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    cyc(2);
    chk8(reg_rdata_o, e);
  endtask : rd
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'h1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (n >= 40) chk8(8'h00, 8'h01);
    cyc(2);
  endtask : wait_done
  task automatic st_run(input logic [21:0] b, input logic sv, input logic s, input logic [31:0] e);
    @(posedge core_clk_i);
    bad   <= b;
    stuck <= sv;
    wr(SBM_ADDR_CTRL, 8'h01, s);
    chk8({7'h00, blank}, 8'h01);
    wait_done();
    for (int i = 0; i < 4; i++) rd(i[7:0], e[31-8*i -: 8]);
    rd(SBM_ADDR_CTRL, 8'h00);
  endtask : st_run
  task automatic drv_ref(input logic m, input logic on);
    @(posedge core_clk_i);
    ref_mismatch_i <= m;
    system_on_i    <= on;
    cyc(3);
  endtask : drv_ref
  task automatic rst();
    @(posedge core_clk_i);
    srst_i         <= 1'h1;
    ref_mismatch_i <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    srst_i         <= 1'h0;
    #1;
  endtask : rst
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // Tests need about 250 cycles; the limit leaves wide margin
  initial begin
    #100_000;
    error_cnt++;
    summarize();
  end

  initial begin
    logic [7:0] d0;
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'h0;
    for (int i = 0; i < 6; i++) rd(i[7:0], 8'h00);
    $display("test reset_values done");
    st_run(22'h0, 1'h0, 1'h0, 32'h0000_0000);
    st_run({7'h41, 7'h02, 4'h8, 4'h1}, 1'h0, 1'h0, 32'h4108_0201);
    st_run({7'h00, 7'h40, 4'h0, 4'h2}, 1'h1, 1'h0, 32'h0000_4002);
    d0 = done_cnt;
    wr(SBM_ADDR_CTRL, 8'h01, 1'h0);
    wr(SBM_ADDR_CTRL, 8'h01, 1'h0);
    wait_done();
    cyc(10);
    chk8(done_cnt - d0, 8'h01);
    $display("test comparator_runs done");
    wr(SBM_ADDR_UV_SW, 8'h40, 1'h0);
    rd(SBM_ADDR_UV_SW, 8'h00);
    @(posedge core_clk_i);
    secure_en_i <= 1'h1;
    wr(SBM_ADDR_UV_LDO, 8'h02, 1'h0);
    rd(SBM_ADDR_UV_LDO, 8'h02);
    wr(SBM_ADDR_UV_LDO, 8'h02, 1'h1);
    rd(SBM_ADDR_UV_LDO, 8'h00);
    wr(SBM_ADDR_CTRL, 8'h01, 1'h0);
    chk8({7'h00, f_hi}, 8'h00);
    st_run(22'h0, 1'h0, 1'h1, 32'h0000_0000);
    $display("test secure done");
    @(posedge core_clk_i);
    secure_en_i    <= 1'h0;
    bad            <= 22'h1;
    powerup_test_i <= 1'h1;
    @(posedge core_clk_i);
    powerup_test_i <= 1'h0;
    wait_done();
    chk8({7'h00, blk}, 8'h00);
    rd(SBM_ADDR_UV_LDO, 8'h01);
    // Bypass set, yet power-up must still be blocked
    wr(SBM_ADDR_CTRL, 8'h02, 1'h0);
    drv_ref(1'h1, 1'h0);
    chk8({6'h00, blk, shut}, 8'h02);
    rd(SBM_ADDR_STATUS, 8'h0B);
    rst();
    drv_ref(1'h1, 1'h1);
    chk8({5'h00, shut, irq, blk}, 8'h06);
    rd(SBM_ADDR_STATUS, 8'h03);
    rst();
    wr(SBM_ADDR_CTRL, 8'h06, 1'h0);
    drv_ref(1'h1, 1'h1);
    chk8({6'h00, shut, irq}, 8'h00);
    rd(SBM_ADDR_STATUS, 8'h03);
    drv_ref(1'h0, 1'h1);
    wr(SBM_ADDR_STATUS, 8'h02, 1'h0);
    rd(SBM_ADDR_STATUS, 8'h00);
    wr(SBM_ADDR_CTRL, 8'h02, 1'h0);
    drv_ref(1'h1, 1'h1);
    chk8({6'h00, shut, irq}, 8'h01);
    $display("test reference done");
    summarize();
  end
endmodule : tb

bind sbm_selftest sbm_selftest_assertions #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .system_on_i(system_on_i), .ref_mismatch_i(ref_mismatch_i),
  .cmp_force_hi_o(cmp_force_hi_o), .cmp_force_lo_o(cmp_force_lo_o), .fault_blank_o(fault_blank_o),
  .switcher_powerup_block_o(switcher_powerup_block_o), .power_stage_shutdown_o(power_stage_shutdown_o),
  .selftest_done_o(selftest_done_o));
